// File: src/vphy_regs_defines.vh
`ifndef VPHY_REGS_DEFINES_VH
`define VPHY_REGS_DEFINES_VH
// register byte offsets
`define OFS_ID_UPPER 9'h1C8
`define OFS_ID_LOWER 9'h1CC
`define OFS_AN_ADV 9'h1D0
// identity reset values (arbitrary neutral values)
`define RST_ID_UPPER 16'h2E71
`define RST_OUI_LOW 6'h2B
`define RST_MODEL 6'h15
`define RST_REV 4'h9
// advertisement field positions
`define POS_NEXT_PAGE 15
`define POS_REMOTE_FAULT 13
`define POS_ASYM_PAUSE 11
`define POS_SYM_PAUSE 10
`define POS_T4 9
`define POS_ABIL_HI 8
`define POS_ABIL_LO 5
`define POS_SEL_HI 4
`define POS_SEL_LO 0
// advertisement reset values
`define RST_ABIL 4'hF
`define RST_SELECTOR 5'h01
// writable bit mask of the advertisement register
`define ADV_WR_MASK 16'h0DFF
`endif

// File: src/reg_field.v
`timescale 1ns/1ns
// ****************************************
// one writable register field
// ****************************************
module reg_field #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_init,
    input wire [WIDTH-1:0] i_init_val,
    input wire i_wr,
    input wire [WIDTH-1:0] i_wr_val,
    output wire [WIDTH-1:0] o_val
);
    reg [WIDTH-1:0] val_ff;
    reg [WIDTH-1:0] nxt_val;
    // write wins over an init in the same cycle as the later command
    always @* begin
        nxt_val = val_ff;
        if (i_init) begin
            nxt_val = i_init_val;
        end
        if (i_wr) begin
            nxt_val = i_wr_val;
        end
    end
    // async reset loads the field's own constant default only
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            val_ff <= RST_VAL;
        end else begin
            val_ff <= nxt_val;
        end
    end
    assign o_val = val_ff;
endmodule // reg_field

// File: src/vphy_id_adv_regs.v
// Function
// (RL1) The upper identifier register holds a 16-bit writable OUI high part.
// (RL2) Lower identifier bits 15:10 hold the writable low six OUI bits.
// (RL3) Lower identifier bits 9:4 hold a writable six-bit model number.
// (RL4) Lower identifier bits 3:0 hold a writable four-bit revision number.
// (RL5) Each register is 32 bits with upper half zero, 16 bits serially.
// (RL6) Advertised next page bit 15 is read-only zero.
// (RL7) Advertised remote fault bit 13 is read-only zero.
// (RL8) Asymmetric (bit 11) and symmetric (bit 10) pause are writable.
// (RL9) Pause bits reset to one if the flow control strap is low, else zero.
// (RL10) Straps are sampled at reset release and held for the defaults.
// (RL11) Advertised 100BASE-T4 bit 9 is read-only zero.
// (RL12) Ability bits 8 to 5 are writable and reset to one.
// (RL13) Selector bits 4:0 reset to 00001 and software writes only that; the code stores any selector value a bus write or the loader gives.
// (RL14) The loader overwrites the whole advertisement after reset or reload; the code loads only the pause, ability and selector bits.
// (RL15) Advertisement changes reach the partner only on auto-neg rerun.
// (RL16) Writes to read-only and reserved bits are ignored.
`timescale 1ns/1ns
`include "vphy_regs_defines.vh"
module vphy_id_adv_regs (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_pause_advert_disable_strap,
    // register bus access
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [8:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire i_serial_access,
    // loader and auto-negotiation controls
    input wire i_loader_wr,
    input wire [15:0] i_loader_data,
    input wire i_autoneg_run,
    // read answer
    output reg [31:0] o_reg_rdata,
    output reg o_reg_hit,
    // live register views and snapshot
    output wire [15:0] o_phy_id_upper,
    output wire [15:0] o_phy_id_lower,
    output wire [15:0] o_advert_live,
    output reg [15:0] o_advert_latched
);

    // ****************************************
    // strap capture
    // ****************************************
    reg strap_taken_ff;
    reg pause_disable_ff;
    reg seed_ff;
    reg seed_d_ff;
    // clocked capture on the first edge after release, never async;
    // seed_d_ff trails the seed so the snapshot sees settled defaults
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            strap_taken_ff <= 1'b0;
            pause_disable_ff <= 1'b0;
            seed_ff <= 1'b0;
            seed_d_ff <= 1'b0;
        end else begin
            seed_d_ff <= seed_ff;
            seed_ff <= 1'b0;
            if (!strap_taken_ff) begin
                strap_taken_ff <= 1'b1;
                pause_disable_ff <= i_pause_advert_disable_strap; // [RL10]
                seed_ff <= 1'b1;
            end
        end
    end

    // ****************************************
    // decode
    // ****************************************
    wire wr_upper = i_reg_wr && (i_reg_addr == `OFS_ID_UPPER);
    wire wr_lower = i_reg_wr && (i_reg_addr == `OFS_ID_LOWER);
    wire wr_adv = i_reg_wr && (i_reg_addr == `OFS_AN_ADV);
    // only the low half is stored, so the parallel and the serial
    // views of each register can never disagree
    wire [15:0] wd = i_reg_wdata[15:0]; // upper half dropped [RL5]

    // ****************************************
    // identifier fields
    // ****************************************
    wire [15:0] id_up;
    wire [5:0] oui_lo;
    wire [5:0] model;
    wire [3:0] rev;
    // each field reloads its default on the seed cycle as well
    reg_field #(
        .WIDTH(16),
        .RST_VAL(`RST_ID_UPPER)
    ) u_id_up (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_init(seed_ff),
        .i_init_val(`RST_ID_UPPER),
        .i_wr(wr_upper),
        .i_wr_val(wd),
        .o_val(id_up)
    ); // [RL1]
    reg_field #(
        .WIDTH(6),
        .RST_VAL(`RST_OUI_LOW)
    ) u_oui_lo (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_init(seed_ff),
        .i_init_val(`RST_OUI_LOW),
        .i_wr(wr_lower),
        .i_wr_val(wd[15:10]),
        .o_val(oui_lo)
    ); // [RL2]
    reg_field #(
        .WIDTH(6),
        .RST_VAL(`RST_MODEL)
    ) u_model (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_init(seed_ff),
        .i_init_val(`RST_MODEL),
        .i_wr(wr_lower),
        .i_wr_val(wd[9:4]),
        .o_val(model)
    ); // [RL3]
    reg_field #(
        .WIDTH(4),
        .RST_VAL(`RST_REV)
    ) u_rev (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_init(seed_ff),
        .i_init_val(`RST_REV),
        .i_wr(wr_lower),
        .i_wr_val(wd[3:0]),
        .o_val(rev)
    ); // [RL4]
    assign o_phy_id_upper = id_up;
    assign o_phy_id_lower = {oui_lo, model, rev};

    // ****************************************
    // advertisement register
    // ****************************************
    // fixed bits have no storage, so no write or load can reach them
    reg [1:0] pause_ff;
    reg [3:0] abil_ff;
    reg [4:0] sel_ff;
    reg [15:0] nxt_adv_src;
    reg adv_load;
    // loader and bus write share one path; bus write wins if both
    always @* begin
        adv_load = i_loader_wr || wr_adv; // [RL14]
        nxt_adv_src = wr_adv ? wd : i_loader_data;
    end
    // only writable fields stored, fixed bits never take a value
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pause_ff <= 2'h0; // strap default lands on the seed cycle
            abil_ff <= `RST_ABIL; // [RL12]
            sel_ff <= `RST_SELECTOR; // [RL13]
        end else if (adv_load) begin
            pause_ff <= nxt_adv_src[`POS_ASYM_PAUSE:`POS_SYM_PAUSE]; // [RL8]
            abil_ff <= nxt_adv_src[`POS_ABIL_HI:`POS_ABIL_LO]; // [RL12]
            sel_ff <= nxt_adv_src[`POS_SEL_HI:`POS_SEL_LO]; // [RL13]
        end else if (seed_ff) begin
            pause_ff <= {2{~pause_disable_ff}}; // [RL9]
        end
    end
    // next page, remote fault, T4 and reserved read zero
    assign o_advert_live = {1'b0, 1'b0, 1'b0, 1'b0, pause_ff, 1'b0,
        abil_ff, sel_ff}; // [RL6] [RL7] [RL11] [RL16]

    // ****************************************
    // auto-negotiation snapshot
    // ****************************************
    // the partner logic sees only the copy taken on a rerun; the reset
    // copy waits one cycle past the seed, else it would catch the pause
    // bits before their strap default has landed
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_advert_latched <= 16'h0000;
        end else if (i_autoneg_run || seed_d_ff) begin
            o_advert_latched <= o_advert_live; // [RL15]
        end
    end

    // ****************************************
    // read port
    // ****************************************
    reg [31:0] nxt_rdata;
    reg nxt_hit;
    // read decode; unmapped offsets answer zero and raise no hit
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_hit = 1'b0;
        case (i_reg_addr)
            `OFS_ID_UPPER: begin
                nxt_rdata = {16'h0000, o_phy_id_upper}; // [RL5]
                nxt_hit = 1'b1;
            end
            `OFS_ID_LOWER: begin
                nxt_rdata = {16'h0000, o_phy_id_lower}; // [RL5]
                nxt_hit = 1'b1;
            end
            `OFS_AN_ADV: begin
                nxt_rdata = {16'h0000, o_advert_live}; // [RL5]
                nxt_hit = 1'b1;
            end
            default: begin
                nxt_rdata = 32'h00000000;
                nxt_hit = 1'b0;
            end
        endcase
    end
    // registered read data, one cycle after the strobe; the data holds
    // until the next read so a slow host may pick it up late, while the
    // hit flag stands for one cycle only
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= 32'h00000000;
            o_reg_hit <= 1'b0;
        end else begin
            o_reg_hit <= i_reg_rd && nxt_hit;
            if (i_reg_rd) begin
                o_reg_rdata <= nxt_rdata;
            end
        end
    end
endmodule // vphy_id_adv_regs

// File: verification/vphy_regs_checker.sv
`timescale 1ns/1ns
// ****
// port checker
// ****
module vphy_regs_checker (
    input wire i_clk_sys, i_rstn, i_reg_wr, i_reg_rd,
    input wire [8:0] i_reg_addr,
    input wire [31:0] i_reg_wdata, o_reg_rdata,
    input wire i_loader_wr, i_autoneg_run, o_reg_hit,
    input wire [15:0] i_loader_data, o_phy_id_upper, o_phy_id_lower,
    input wire [15:0] o_advert_live, o_advert_latched
);
    wire [15:0] d = i_reg_wdata[15:0];
    wire aw = i_reg_wr && i_reg_addr == 9'h1D0;
    wire map = i_reg_addr inside {9'h1C8, 9'h1CC, 9'h1D0};
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    a_fixed_zero: assert property (
        (o_advert_live & 16'hF200) == 16'h0000) else $error("fixed");
    a_rd_upper: assert property (
        o_reg_rdata[31:16] == 16'h0000) else $error("upper half");
    a_adv_write: assert property (
        aw |=> o_advert_live == ($past(d) & 16'h0DFF)) else $error("adv");
    a_id_upper: assert property (
        i_reg_wr && i_reg_addr == 9'h1C8 |=> o_phy_id_upper == $past(d))
        else $error("id up");
    a_id_lower: assert property (
        i_reg_wr && i_reg_addr == 9'h1CC |=> o_phy_id_lower == $past(d))
        else $error("id low");
    a_loader_write: assert property (
        i_loader_wr && !aw |=> o_advert_live ==
        ($past(i_loader_data) & 16'h0DFF)) else $error("loader");
    a_rd_hit: assert property (
        i_reg_rd |=> o_reg_hit == $past(map)) else $error("hit");
    a_latch_run: assert property (
        i_autoneg_run |=> o_advert_latched == $past(o_advert_live))
        else $error("latch");
endmodule // vphy_regs_checker
bind vphy_id_adv_regs vphy_regs_checker i_chk (.i_clk_sys, .i_rstn,
    .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_loader_wr, .i_autoneg_run, .o_reg_hit, .i_loader_data,
    .o_phy_id_upper, .o_phy_id_lower, .o_advert_live, .o_advert_latched);

// File: verification/vphy_mgmt_host.sv
`timescale 1ns/1ns
// ****
// management host model
// ****
module vphy_mgmt_host (
    input wire i_clk_sys,
    input wire [31:0] i_reg_rdata,
    input wire i_reg_hit,
    output reg o_reg_wr = 1'b0,
    output reg o_reg_rd = 1'b0,
    output reg [8:0] o_reg_addr = 9'h000,
    output reg [31:0] o_reg_wdata = 32'h00000000
);
    // strobe one cycle; reserved half always set to prove it is dropped
    task wr_reg(input [8:0] a, input [15:0] v);
        begin
            @(posedge i_clk_sys);
            #1;
            o_reg_addr = a;
            o_reg_wdata = {16'hFFFF, v};
            if (a == 9'h1D0) o_reg_wdata[4:0] = 5'h01;
            o_reg_wr = 1'b1;
            @(posedge i_clk_sys);
            #1;
            o_reg_wr = 1'b0;
            o_reg_addr = ~a; // released bus shows no stale value
            o_reg_wdata = ~o_reg_wdata;
        end
    endtask
    task rd_reg(input [8:0] a, output [31:0] q, output h);
        begin
            @(posedge i_clk_sys);
            #1;
            o_reg_addr = a;
            o_reg_rd = 1'b1;
            @(posedge i_clk_sys);
            #1;
            o_reg_rd = 1'b0;
            o_reg_addr = ~a;
            q = i_reg_rdata;
            h = i_reg_hit;
        end
    endtask
endmodule // vphy_mgmt_host

// File: verification/virtual_phy_id_autoneg_adv_regs_tb_top.sv
`timescale 1ns/1ns
// ****
// register slice bench
// ****
module virtual_phy_id_autoneg_adv_regs_tb_top;
    reg i_clk_sys, i_rstn, i_pause_advert_disable_strap, h;
    reg i_loader_wr = 1'b0, i_autoneg_run = 1'b0;
    reg [15:0] i_loader_data = 16'h0000;
    reg [31:0] q;
    wire i_reg_wr, i_reg_rd, o_reg_hit;
    wire [8:0] i_reg_addr;
    wire [31:0] i_reg_wdata, o_reg_rdata;
    wire [15:0] o_phy_id_upper, o_phy_id_lower, o_advert_live;
    wire [15:0] o_advert_latched;
    integer n_fail = 0, comparisons = 0, cyc = 0;
    vphy_id_adv_regs i_dut (.i_clk_sys, .i_rstn, .i_serial_access(1'b0),
        .i_pause_advert_disable_strap, .i_reg_wr, .i_reg_rd, .i_reg_addr,
        .i_reg_wdata, .i_loader_wr, .i_loader_data, .i_autoneg_run,
        .o_reg_rdata, .o_reg_hit, .o_phy_id_upper, .o_phy_id_lower,
        .o_advert_live, .o_advert_latched);
    vphy_mgmt_host i_host (.i_clk_sys, .i_reg_rdata(o_reg_rdata),
        .i_reg_hit(o_reg_hit), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
        .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
    task end_sim;
        begin
            $display("n_fail %0d comparisons %0d", n_fail, comparisons);
            if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: %h not %h", $time, g, e);
            end
        end
    endtask
    task rd(input [8:0] a, input [31:0] e, input eh);
        begin
            i_host.rd_reg(a, q, h);
            chk(q, e);
            chk({31'h0, h}, {31'h0, eh});
        end
    endtask
    // strap flips after release; the held copy must not follow it
    task do_reset(input s);
        begin
            i_rstn = 1'b0;
            i_pause_advert_disable_strap = s;
            repeat (2) @(posedge i_clk_sys);
            #1 i_rstn = 1'b1;
            repeat (3) @(posedge i_clk_sys);
            #1 i_pause_advert_disable_strap = ~s;
        end
    endtask
    task pulse(input l);
        begin
            @(posedge i_clk_sys);
            #1 {i_loader_wr, i_autoneg_run} = {l, ~l};
            @(posedge i_clk_sys);
            #1 {i_loader_wr, i_autoneg_run} = 2'b00;
        end
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            n_fail = n_fail + 1;
            end_sim;
        end
    end
    initial begin
        do_reset(1'b0);
        rd(9'h1C8, 32'h00002E71, 1'b1);
        rd(9'h1CC, 32'h0000AD59, 1'b1);
        rd(9'h1D0, 32'h0DE1, 1'b1);
        i_host.wr_reg(9'h1C8, 16'hA5C3);
        i_host.wr_reg(9'h1CC, 16'h5A3C);
        i_host.wr_reg(9'h1D0, 16'hFFFF);
        rd(9'h1C8, 32'hA5C3, 1'b1);
        rd(9'h1CC, 32'h5A3C, 1'b1);
        rd(9'h1D0, 32'h0DE1, 1'b1);
        i_host.wr_reg(9'h1D0, 16'h0000);
        chk({16'h0, o_advert_latched}, 32'h0DE1);
        pulse(1'b0);
        chk({16'h0, o_advert_latched}, 32'h0001);
        i_loader_data = 16'hFFFF;
        pulse(1'b1);
        rd(9'h1D0, 32'h0DFF, 1'b1);
        rd(9'h1D4, 32'h0, 1'b0);
        do_reset(1'b1);
        rd(9'h1D0, 32'h01E1, 1'b1);
        chk({16'h0, o_advert_latched}, 32'h01E1);
        rd(9'h1C8, 32'h00002E71, 1'b1);
        rd(9'h1CC, 32'h0000AD59, 1'b1);
        end_sim;
    end
endmodule // virtual_phy_id_autoneg_adv_regs_tb_top
